// File: include/fdw_pkg.sv
package fdw_pkg;
    localparam logic [15:0] FDW_FLASH_LO = 16'h1000;
    localparam logic [15:0] FDW_FLASH_HI = 16'h2FFF;
    localparam int FDW_PAGES = 64;
    localparam int FDW_PAGE_BYTES = 128;
    localparam int FDW_BUF_BYTES = 64;
    localparam int FDW_ARRAY_BYTES = FDW_PAGES * FDW_PAGE_BYTES;
    localparam logic [7:0] FDW_ERASED = 8'hFF;
    localparam int FDW_MIN_ACCESS_CYC = 4;
    localparam int FDW_CLK_HZ = 10_000_000;
    localparam int FDW_ERASE_US = 100;
    localparam int FDW_PROG_US = 100;
    localparam int FDW_ERASE_CYC = FDW_ERASE_US * (FDW_CLK_HZ / 1_000_000);
    localparam int FDW_PROG_CYC = FDW_PROG_US * (FDW_CLK_HZ / 1_000_000);

    // Wishbone register map, word aligned byte addresses.
    localparam logic [3:0] FDW_REG_CTRL = 4'h0;
    localparam logic [3:0] FDW_REG_STAT = 4'h4;

    // Control register field positions.
    localparam int FDW_CTRL_CODE_SEL = 7;
    localparam int FDW_CTRL_AUTO_ERASE = 6;
    localparam int FDW_CTRL_LOAD_BUF = 5;
    localparam int FDW_CTRL_WR_EN = 4;
    localparam int FDW_CTRL_DF_EN = 3;
    localparam int FDW_CTRL_PROG_ERR = 2;
    localparam int FDW_CTRL_WR_INH_N = 0;
    localparam logic [7:0] FDW_CTRL_RESET = 8'h00;

    typedef enum logic [2:0] {
        FDW_SPACE_NONE = 3'h0,
        FDW_SPACE_FLASH = 3'h1,
        FDW_SPACE_EXTERNAL = 3'h2,
        FDW_SPACE_CODE = 3'h3,
        FDW_SPACE_EXTRA = 3'h4
    } fdw_space_t;

    typedef struct packed {
        logic valid;
        logic we;
        logic data_pointer_reg;
        logic [15:0] addr;
        logic [7:0] wdata;
    } fdw_move_t;

    typedef struct packed {
        logic done;
        logic [7:0] rdata;
        fdw_space_t space;
    } fdw_resp_t;
endpackage : fdw_pkg

// File: core/fdw_writer.sv
module fdw_writer
    import fdw_pkg::*;
#(
    parameter int ERASE_CYC = FDW_ERASE_CYC,
    parameter int PROG_CYC = FDW_PROG_CYC
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire fdw_move_t move_i,
    output fdw_resp_t resp_o,
    output logic cpu_hold_o,
    output logic irq_defer_o,
    input wire logic brownout_detector_i
);
    localparam int CNT_W = $clog2((ERASE_CYC > PROG_CYC ? ERASE_CYC : PROG_CYC) + 1) + 1;
    localparam logic [CNT_W-1:0] ERASE_LAST = CNT_W'(ERASE_CYC - 1);
    localparam logic [CNT_W-1:0] PROG_LAST = CNT_W'(PROG_CYC - 1);
    localparam logic [2:0] ACC_LAST = 3'(FDW_MIN_ACCESS_CYC - 1);

    typedef enum logic [4:0] {
        FDW_ST_IDLE = 5'b00001,
        FDW_ST_ACCESS = 5'b00010,
        FDW_ST_ERASE = 5'b00100,
        FDW_ST_PROG = 5'b01000,
        FDW_ST_DONE = 5'b10000
    } fdw_state_t;

    fdw_state_t state_q;
    logic [7:0] mem_q [FDW_ARRAY_BYTES];
    logic [7:0] buf_data_q [FDW_BUF_BYTES];
    logic [FDW_BUF_BYTES-1:0] buf_used_q;
    logic code_program_select_q;
    logic auto_erase_select_q;
    logic load_buffer_mode_q;
    logic nv_write_enable_q;
    logic data_flash_enable_q;
    logic prog_err_q;
    logic [CNT_W-1:0] cnt_q;
    logic [2:0] acc_cnt_q;
    logic [5:0] tgt_page_q;
    logic tgt_half_q;
    logic [5:0] tgt_off_q;
    logic [7:0] tgt_data_q;
    logic single_q;
    logic [6:0] prog_idx_q;
    logic [7:0] rdata_q;
    logic is_wr_q;
    fdw_space_t space_q;

    function automatic fdw_space_t decode(input fdw_move_t m, input logic cs, input logic en);
        fdw_space_t s;
        s = FDW_SPACE_EXTERNAL;
        if (m.data_pointer_reg && cs) begin
            s = FDW_SPACE_CODE;
        end else if (m.addr < FDW_FLASH_LO) begin
            s = FDW_SPACE_EXTRA;
        end else if (m.data_pointer_reg && en && m.addr <= FDW_FLASH_HI) begin
            s = FDW_SPACE_FLASH;
        end
        return s;
    endfunction : decode

    function automatic logic [12:0] flash_ofs(input logic [15:0] a);
        logic [15:0] d;
        d = a - FDW_FLASH_LO;
        return d[12:0];
    endfunction : flash_ofs

    // Busy means the array is being erased or programmed and the CPU must idle.
    function automatic logic write_busy(input fdw_state_t s, input logic last);
        logic b;
        b = 1'b0;
        if (s == FDW_ST_ERASE) begin
            b = 1'b1;
        end else if (s == FDW_ST_PROG && !last) begin
            b = 1'b1;
        end
        return b;
    endfunction : write_busy

    // A flash write only programs zeroes, so ones in the new data keep the old bits.
    function automatic logic [7:0] prog_mask(input logic [7:0] old_v, input logic [7:0] new_v);
        return old_v & new_v;
    endfunction : prog_mask

    // Status word: busy, brown-out, buffer in use, error, hold and deferral.
    function automatic logic [31:0] status_word(input logic busy, input logic bo,
        input logic used, input logic err, input logic hold, input logic defer);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[5] = busy;
        w[4] = bo;
        w[3] = used;
        w[2] = err;
        w[1] = hold;
        w[0] = defer;
        return w;
    endfunction : status_word

    // A write sequence starts only with every enable up and no brown-out present.
    function automatic logic write_allowed(input logic wr, input logic wen,
        input logic ldm, input logic bo);
        logic ok;
        ok = wr && wen;
        if (ldm || bo) begin
            ok = 1'b0;
        end
        return ok;
    endfunction : write_allowed

    logic buf_wr;
    logic wr_go;
    logic busy_now;
    logic wb_req;
    logic [7:0] ctrl_rd;
    fdw_space_t move_space;
    logic [12:0] move_ofs;
    logic prog_done;

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign ctrl_rd = {code_program_select_q, auto_erase_select_q, load_buffer_mode_q,
                      nv_write_enable_q, data_flash_enable_q, prog_err_q, 1'b0,
                      !brownout_detector_i};
    assign move_space = decode(move_i, code_program_select_q, data_flash_enable_q);
    assign move_ofs = flash_ofs(move_i.addr);
    assign prog_done = (state_q == FDW_ST_PROG) && (cnt_q == PROG_LAST);
    assign buf_wr = (state_q == FDW_ST_ACCESS) && (space_q == FDW_SPACE_FLASH) && is_wr_q
                    && nv_write_enable_q && (acc_cnt_q == ACC_LAST);
    assign wr_go = write_allowed(is_wr_q && space_q == FDW_SPACE_FLASH, nv_write_enable_q,
                                 load_buffer_mode_q, brownout_detector_i);
    assign busy_now = write_busy(state_q, prog_done);

    // Wishbone slave: one wait state, ack drops the cycle after it rises.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    // Read data is registered and stands until the next read.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_req && !wb_we_i) begin
            unique case (wb_adr_i)
                FDW_REG_CTRL: wb_dat_o <= {24'h00_0000, ctrl_rd};
                FDW_REG_STAT: wb_dat_o <= status_word(state_q != FDW_ST_IDLE,
                                                      brownout_detector_i, buf_used_q != '0,
                                                      prog_err_q, cpu_hold_o, irq_defer_o);
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // Control bits written by software.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            code_program_select_q <= 1'b0;
            auto_erase_select_q <= 1'b0;
            load_buffer_mode_q <= 1'b0;
            nv_write_enable_q <= 1'b0;
            data_flash_enable_q <= 1'b0;
        end else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == FDW_REG_CTRL) begin
            code_program_select_q <= wb_dat_i[FDW_CTRL_CODE_SEL];
            auto_erase_select_q <= wb_dat_i[FDW_CTRL_AUTO_ERASE];
            load_buffer_mode_q <= wb_dat_i[FDW_CTRL_LOAD_BUF];
            nv_write_enable_q <= wb_dat_i[FDW_CTRL_WR_EN];
            data_flash_enable_q <= wb_dat_i[FDW_CTRL_DF_EN];
        end
    end

    // Error flag; hardware never clears it, and its set wins over a same-cycle clear.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            prog_err_q <= 1'b0;
        end else if ((state_q == FDW_ST_ERASE || state_q == FDW_ST_PROG)
                     && brownout_detector_i) begin
            prog_err_q <= 1'b1;
        end else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == FDW_REG_CTRL) begin
            prog_err_q <= wb_dat_i[FDW_CTRL_PROG_ERR];
        end
    end

    // Sequencer for accesses, erase and program.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= FDW_ST_IDLE;
            cnt_q <= '0;
            acc_cnt_q <= 3'h0;
            tgt_page_q <= 6'h00;
            tgt_half_q <= 1'b0;
            tgt_off_q <= 6'h00;
            tgt_data_q <= 8'h00;
            single_q <= 1'b0;
            prog_idx_q <= 7'h00;
            is_wr_q <= 1'b0;
            space_q <= FDW_SPACE_NONE;
            rdata_q <= 8'h00;
        end else begin
            unique case (state_q)
                FDW_ST_IDLE: begin
                    if (move_i.valid) begin
                        space_q <= move_space;
                        is_wr_q <= move_i.we;
                        acc_cnt_q <= 3'h0;
                        tgt_page_q <= move_ofs[12:7];
                        tgt_half_q <= move_ofs[6];
                        tgt_off_q <= move_ofs[5:0];
                        tgt_data_q <= move_i.wdata;
                        single_q <= (buf_used_q == '0);
                        rdata_q <= mem_q[move_ofs];
                        state_q <= FDW_ST_ACCESS;
                    end
                end
                FDW_ST_ACCESS: begin
                    acc_cnt_q <= acc_cnt_q + 3'h1;
                    if (space_q != FDW_SPACE_FLASH || acc_cnt_q == ACC_LAST) begin
                        state_q <= FDW_ST_DONE;
                        cnt_q <= '0;
                        prog_idx_q <= 7'h00;
                        if (wr_go) begin
                            state_q <= auto_erase_select_q ? FDW_ST_ERASE : FDW_ST_PROG;
                        end
                    end
                end
                FDW_ST_ERASE: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == ERASE_LAST) begin
                        cnt_q <= '0;
                        state_q <= FDW_ST_PROG;
                    end
                end
                FDW_ST_PROG: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == PROG_LAST) begin
                        state_q <= FDW_ST_DONE;
                    end
                end
                FDW_ST_DONE: begin
                    state_q <= FDW_ST_IDLE;
                end
            endcase
        end
    end

    // Page buffer; outside load buffer mode a brown-out abandons the write but still empties it.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            buf_used_q <= '0;
        end else if (prog_done) begin
            buf_used_q <= '0;
        end else if (buf_wr) begin
            if (!load_buffer_mode_q) begin
                if (brownout_detector_i) begin
                    buf_used_q <= '0;
                end
            end else begin
                buf_used_q[tgt_off_q] <= 1'b1;
            end
        end
    end

    // Buffer data holds no reset; only used bits are ever consulted.
    always_ff @(posedge sys_clk) begin
        if (buf_wr) begin
            buf_data_q[tgt_off_q] <= tgt_data_q;
        end
    end

    // The array is nonvolatile, so it has no reset and comes up erased.
    initial begin
        for (int i = 0; i < FDW_ARRAY_BYTES; i++) begin
            mem_q[i] = FDW_ERASED;
        end
    end

    // Erase walks the page one byte per cycle; program applies at its end.
    always_ff @(posedge sys_clk) begin
        if (state_q == FDW_ST_ERASE && !brownout_detector_i
            && cnt_q < CNT_W'(FDW_PAGE_BYTES)) begin
            mem_q[{tgt_page_q, cnt_q[6:0]}] <= FDW_ERASED;
        end else if (prog_done && !brownout_detector_i) begin
            for (int j = 0; j < FDW_BUF_BYTES; j++) begin
                if ((single_q && j == int'(tgt_off_q)) || (!single_q &&
                    (buf_used_q[j] || j == int'(tgt_off_q)))) begin
                    mem_q[{tgt_page_q, tgt_half_q, 6'(j)}] <=
                        prog_mask(mem_q[{tgt_page_q, tgt_half_q, 6'(j)}],
                                  (j == int'(tgt_off_q)) ? tgt_data_q : buf_data_q[j]);
                end
            end
        end
    end

    // Done comes only from the done state, so the CPU sees exactly one pulse per move.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            resp_o <= '0;
        end else begin
            resp_o.done <= (state_q == FDW_ST_DONE);
            resp_o.rdata <= rdata_q;
            resp_o.space <= space_q;
        end
    end

    // CPU idle request while the array is busy.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cpu_hold_o <= 1'b0;
        end else begin
            cpu_hold_o <= busy_now;
        end
    end

    // Peripherals are never gated here; interrupt servicing waits for the write, as the CPU held by cpu_hold_o does.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_defer_o <= 1'b0;
        end else begin
            irq_defer_o <= busy_now;
        end
    end
endmodule : fdw_writer

// File: testbench/fdw_writer_chk.sv
module fdw_writer_chk
    import fdw_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire fdw_move_t move_i,
    input wire fdw_resp_t resp_o,
    input wire logic cpu_hold_o,
    input wire logic irq_defer_o,
    input wire logic brownout_detector_i
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);
    a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    a_hold_defer_same: assert property (cpu_hold_o == irq_defer_o)
        else $error("defer differs from hold");
    a_done_one_pulse: assert property (resp_o.done |=> !resp_o.done)
        else $error("done too long");
    a_flash_min_cyc: assert property (resp_o.done && resp_o.space == FDW_SPACE_FLASH
        |-> !$past(move_i.valid) && !$past(move_i.valid, 2) && !$past(move_i.valid, 3))
        else $error("flash move too short");
    a_short_ptr_ext: assert property (move_i.valid && !move_i.data_pointer_reg
        && move_i.addr >= FDW_FLASH_LO |-> ##3 resp_o.done && resp_o.space == FDW_SPACE_EXTERNAL)
        else $error("short pointer move not external");
    a_above_top_ext: assert property (move_i.valid && move_i.data_pointer_reg
        && move_i.addr > FDW_FLASH_HI |-> ##3 resp_o.done && resp_o.space == FDW_SPACE_EXTERNAL)
        else $error("high address not external");
    a_bo_no_start: assert property (brownout_detector_i [*2] |-> !$rose(cpu_hold_o))
        else $error("write started in brown-out");
    a_inh_reads_bo: assert property (wb_ack_o && !$past(wb_we_i)
        && $past(wb_adr_i) == FDW_REG_CTRL
        |-> wb_dat_o[FDW_CTRL_WR_INH_N] == !$past(brownout_detector_i))
        else $error("inhibit bit wrong");
    c_write: cover property ($rose(cpu_hold_o));
    c_flash: cover property (resp_o.done && resp_o.space == FDW_SPACE_FLASH);
    c_bo_write: cover property (brownout_detector_i && cpu_hold_o);
endmodule : fdw_writer_chk

bind fdw_writer fdw_writer_chk u_fdw_writer_chk (.sys_clk, .arst_n, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .move_i, .resp_o, .cpu_hold_o, .irq_defer_o,
    .brownout_detector_i);

// File: testbench/fdw_cpu_model.sv
module fdw_cpu_model
    import fdw_pkg::*;
(
    input wire logic sys_clk,
    input wire fdw_resp_t resp_i,
    output fdw_move_t move_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial move_o = '0;
    // One move at a time; the caller decides the spacing, so slow and quick issue both occur.
    task automatic mov(input logic w, input logic dp, input logic [15:0] a,
        input logic [7:0] d, output logic [7:0] r);
        move_o <= '{1'b1, w, dp, a, d};
        @(posedge sys_clk);
        // Released lines must not keep the last value.
        move_o <= '{1'b0, ~w, ~dp, ~a, ~d};
        while (resp_i.done !== 1'b1) begin
            @(posedge sys_clk);
        end
        r = resp_i.rdata;
    endtask : mov
endmodule : fdw_cpu_model

// File: testbench/tb.sv
module tb
    import fdw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] LO = FDW_FLASH_LO;
    logic sys_clk, arst_n, cyc, stb, we, bo, hold, defer, ack, seen;
    logic [3:0] adr;
    logic [31:0] dw, dr, q;
    logic [7:0] rd, d;
    logic [15:0] a, pg;
    logic [7:0] mem [FDW_ARRAY_BYTES];
    fdw_move_t mv;
    fdw_resp_t rs;
    int mismatches, n_tests;
    fdw_writer #(.ERASE_CYC(130), .PROG_CYC(2)) u_fdw_writer (.sys_clk, .arst_n,
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .move_i(mv), .resp_o(rs),
        .cpu_hold_o(hold), .irq_defer_o(defer), .brownout_detector_i(bo));
    fdw_cpu_model u_fdw_cpu_model (.sys_clk, .resp_i(rs), .move_o(mv));
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (hold && defer) seen <= 1'b1;
    end
    function automatic logic [7:0] prog(input logic [7:0] o, input logic [7:0] n);
        return o & n;
    endfunction : prog
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, s, e);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [3:0] ad, input logic [31:0] v);
        {cyc, stb, we, adr, dw} <= {2'b11, w, ad, v};
        do begin
            @(posedge sys_clk);
        end while (ack !== 1'b1);
        q = dr;
        {cyc, stb} <= 2'b00;
        @(posedge sys_clk);
    endtask : wb
    task automatic ctl(input logic [7:0] v);
        wb(1'b1, FDW_REG_CTRL, {24'h0, v});
    endtask : ctl
    task automatic mw(input logic [15:0] ad, input logic [7:0] v, input logic up);
        u_fdw_cpu_model.mov(1'b1, 1'b1, ad, v, rd);
        if (up) mem[ad - LO] = prog(mem[ad - LO], v);
    endtask : mw
    task automatic rc(input logic [15:0] ad);
        u_fdw_cpu_model.mov(1'b0, 1'b1, ad, 8'h5A, rd);
        chk({24'h0, rd}, {24'h0, mem[ad - LO]});
    endtask : rc
    task automatic spc(input logic [7:0] c, input logic dp, input logic [15:0] ad,
        input fdw_space_t e);
        ctl(c);
        u_fdw_cpu_model.mov(1'b0, dp, ad, 8'h00, rd);
        chk({29'h0, rs.space}, {29'h0, e});
    endtask : spc
    task automatic tally_and_finish;
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        tally_and_finish();
    end
    initial begin
        arst_n = 1'b0;
        {cyc, stb, we, adr, dw, bo, seen} = '0;
        foreach (mem[i]) mem[i] = FDW_ERASED;
        d = 8'($urandom(68));
        repeat (3) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        wb(1'b0, FDW_REG_CTRL, '0);
        chk(q, 32'h01);
        wb(1'b1, 4'h8, 32'hFF);
        wb(1'b0, 4'h8, '0);
        chk(q, 32'h0);
        ctl(8'h00);
        u_fdw_cpu_model.mov(1'b0, 1'b1, LO, 8'h00, rd);
        chk({31'h0, rs.space == FDW_SPACE_FLASH}, 32'h0);
        spc(8'h08, 1'b1, 16'h2FFF, FDW_SPACE_FLASH);
        spc(8'h08, 1'b0, 16'h1800, FDW_SPACE_EXTERNAL);
        spc(8'h08, 1'b1, 16'h3000, FDW_SPACE_EXTERNAL);
        spc(8'h08, 1'b1, 16'h0FFF, FDW_SPACE_EXTRA);
        spc(8'h88, 1'b1, LO, FDW_SPACE_CODE);
        ctl(8'h08);
        mw(16'h1234, 8'h00, 1'b0);
        rc(16'h1234);
        ctl(8'h18);
        for (int i = 0; i < 5; i++) begin
            a = (i == 0) ? 16'h2FFE : LO + 16'($urandom_range(FDW_ARRAY_BYTES - 2));
            seen <= 1'b0;
            mw(a, 8'($urandom), 1'b1);
            chk({31'h0, seen}, 32'h1);
            mw(a, 8'($urandom), 1'b1);
            rc(a);
            rc(a + 16'h1);
        end
        pg = LO + {3'h0, 6'($urandom_range(62)), 7'h00};
        ctl(8'h38);
        seen <= 1'b0;
        for (int i = 'h78; i < 'h80; i++) mw(pg + 16'(i), 8'($urandom), 1'b1);
        chk({31'h0, seen}, 32'h0);
        wb(1'b0, FDW_REG_STAT, '0);
        chk({31'h0, q[3]}, 32'h1);
        ctl(8'h18);
        mw(pg + 16'h0040, 8'($urandom), 1'b1);
        wb(1'b0, FDW_REG_STAT, '0);
        chk({31'h0, q[3]}, 32'h0);
        for (int i = 'h78; i < 'h80; i++) rc(pg + 16'(i));
        rc(pg + 16'h0040);
        ctl(8'h58);
        d = 8'($urandom);
        mw(pg + 16'h0010, d, 1'b0);
        for (int i = 0; i < FDW_PAGE_BYTES; i++) mem[pg - LO + i] = FDW_ERASED;
        mem[pg - LO + 16'h10] = d;
        rc(pg + 16'h0010);
        rc(pg + 16'h0078);
        ctl(8'h18);
        mw(pg + 16'h0050, 8'h3C, 1'b1);
        rc(pg + 16'h0050);
        rc(pg + 16'h007F);
        bo <= 1'b1;
        @(posedge sys_clk);
        wb(1'b0, FDW_REG_CTRL, '0);
        chk(q, 32'h18);
        seen <= 1'b0;
        mw(pg + 16'h0011, 8'h00, 1'b0);
        chk({31'h0, seen}, 32'h0);
        rc(pg + 16'h0011);
        bo <= 1'b0;
        ctl(8'h58);
        // The page behind a torn write is left undefined, so it is never read again.
        fork
            mw(pg ^ 16'h0080, 8'h00, 1'b0);
            begin
                repeat (20) @(posedge sys_clk);
                bo <= 1'b1;
            end
        join
        bo <= 1'b0;
        @(posedge sys_clk);
        wb(1'b0, FDW_REG_CTRL, '0);
        chk({31'h0, q[2]}, 32'h1);
        ctl(8'h18);
        wb(1'b0, FDW_REG_CTRL, '0);
        chk(q, 32'h19);
        tally_and_finish();
    end
endmodule : tb
